/* File: hw/bbsd_fifo.sv */
// Sample FIFO with registered full and empty flags
`timescale 1ns/1ns
module bbsd_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstN,
  bbsd_stream_if.snk inS,
  bbsd_stream_if.src outS
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
  begin : g_bad
    $error("bbsd_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic ready_r;
  logic valid_r;
  wire push = inS.valid && ready_r;
  wire pop = valid_r && outS.ready;

  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign inS.ready = ready_r;
  assign outS.valid = valid_r;
  assign outS.data = mem[rdPtr_r];

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
      valid_r <= 1'b0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + AW'(push);
      rdPtr_r <= rdPtr_r + AW'(pop);
      cnt_r <= cnt_nxt;
      ready_r <= cnt_nxt != FULL_CNT;
      valid_r <= cnt_nxt != '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_r] <= inS.data;
  end
endmodule

/* File: hw/bbsd_pkg.sv */
// Shared constants and types of the baseband filter and signal detector
package bbsd_pkg;
  localparam logic [4:0] OSR_MIN = 5'h08;
  localparam logic [4:0] OSR_MAX = 5'h10;
  localparam logic [4:0] OUT_PER_CHIP = 5'h08;
  localparam int WIN_LEN = 16;
  localparam int RECIP_SHIFT = 8;
  localparam logic [8:0] RECIP_ONE = 9'h100;
  localparam int INTERP_SHIFT = 3;
  localparam int POW_SHIFT = 4;
  localparam int POW_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int SAMPLE_W = 12;
  localparam logic [1:0] CHIP_HALF_END = 2'h3;
  localparam logic [2:0] CHIP_START = 3'h0;
  localparam logic [4:0] ACC_RESET = 5'h00;
  localparam logic [15:0] POW_RESET = 16'h0000;
  typedef enum logic [1:0] {MODE_SIG, MODE_NOISE, MODE_BOTH, MODE_GATED} bbsd_mode_type;
endpackage

/* File: hw/bbsd_stream_if.sv */
// Valid/ready sample stream between the block's own modules
`timescale 1ns/1ns
interface bbsd_stream_if #(parameter int W = 12);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

/* File: hw/bbsd_top.sv */
// Matched filter, rate converter and signal/noise detection of the baseband receiver
// Operation
// (RULE1) Input stream accepts 8 to 16 samples per chip, set by configuration.
// (RULE2) Matched filter averages over one chip, following the oversampling factor.
// (RULE3) Linear interpolation converter decimates by oversampling over eight, from 1 to 2.
// (RULE4) Converter output always carries eight samples per chip.
// (RULE5) Signal power is measured, readable, and flags data above the threshold.
// (RULE6) Noise power is measured on the converter output for FSK.
// (RULE7) Noise power below noise threshold declares a data signal.
// (RULE8) Readable noise power refreshes on every serial controller access.
// (RULE9) Modes: signal detector only, noise detector only, or both together.
// (RULE10) Fourth mode gates noise detection by signal power above low threshold.
// (RULE11) Software picks signal-only mode for ASK and wide-deviation FSK.
// (RULE12) Recognition result drives a wake-up level output.
// (RULE13) Recovered data and recovered clock leave on two separate pins.
// (RULE14) Software sets ASK threshold from 500 idle readings, mean plus two deviations.
// (RULE15) Software checks signal-only sufficiency with a minimum deviation test signal.
// (RULE16) Software sets noise threshold to idle mean minus one deviation.
// (RULE17) Software programs the low threshold whenever the noise detector is used.
// (RULE18) Software calibrates low threshold using low range enable and range select.
// (RULE19) Detector decision is re-evaluated per converter sample into one registered flag.
`timescale 1ns/1ns
module bbsd_top #(
  parameter int W = bbsd_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = bbsd_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] sampleIn,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [4:0] oversampleRate,
  input wire logic [1:0] recognitionMode,
  input wire logic [7:0] signalThresholdLowByte,
  input wire logic [7:0] signalThresholdHighByte,
  input wire logic [15:0] noiseThreshold,
  input wire logic [7:0] signalLowThreshold,
  input wire logic lowRangeCalibEnable,
  input wire logic [1:0] lowRangeSelect,
  input wire logic serialAccess,
  output logic [15:0] signalPowerValue,
  output logic [15:0] noisePowerValue,
  output logic [W-1:0] filtSample,
  output logic filtValid,
  input wire logic filtReady,
  output logic signalValid,
  output logic wakeLevel,
  output logic recoveredData,
  output logic recoveredClk
);
  if (W < 8 || W > 16)
  begin : g_bad
    $error("bbsd_top: W must lie between 8 and 16");
  end

  function automatic logic [4:0] clampOsr(input logic [4:0] r);
    if (r < bbsd_pkg::OSR_MIN)
      clampOsr = bbsd_pkg::OSR_MIN;
    else if (r > bbsd_pkg::OSR_MAX)
      clampOsr = bbsd_pkg::OSR_MAX;
    else
      clampOsr = r;
  endfunction

  function automatic logic [15:0] sqTop(input logic signed [W-1:0] v);
    logic [2*W-1:0] s;
    s = (2*W)'(v * v);
    sqTop = 16'(s >> (2 * W - bbsd_pkg::POW_W));
  endfunction

  function automatic logic [15:0] leak(input logic [15:0] p, input logic [15:0] s);
    logic signed [16:0] d;
    d = $signed({1'b0, s}) - $signed({1'b0, p});
    leak = 16'($signed({1'b0, p}) + (d >>> bbsd_pkg::POW_SHIFT));
  endfunction

  logic rstMeta_r;
  logic rstN;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end
  end

  bbsd_stream_if #(.W(W)) pushIf();
  bbsd_stream_if #(.W(W)) popIf();

  logic filtValid_r;
  wire advance = !filtValid_r || filtReady;
  wire fire = popIf.valid && advance;

  assign pushIf.data = sampleIn;
  assign pushIf.valid = sampleValid;
  assign popIf.ready = advance;
  assign sampleReady = pushIf.ready;

  bbsd_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rstN(rstN),
    .inS(pushIf),
    .outS(popIf)
  );

  // Matched filter: running chip-long average
  logic signed [W-1:0] win_r [bbsd_pkg::WIN_LEN];
  logic signed [W+4:0] sum_r;
  logic [4:0] osrHeld_r;
  wire [4:0] osrEff = clampOsr(oversampleRate); // RULE1
  wire osrChange = osrEff != osrHeld_r;
  wire [3:0] oldIdx = 4'(osrEff - 5'h01);
  wire signed [W-1:0] xIn = $signed(popIf.data);
  wire signed [W+4:0] sumNxt = sum_r + (W+5)'(xIn) - (W+5)'(win_r[oldIdx]); // RULE2
  wire [8:0] recip = 9'(bbsd_pkg::RECIP_ONE / 9'(osrEff));
  wire signed [W+13:0] mfProd = sumNxt * $signed(recip); // RULE2
  wire signed [W-1:0] mfOut = W'(mfProd >>> bbsd_pkg::RECIP_SHIFT);

  // Rate converter: eight outputs per chip by linear interpolation
  logic [4:0] acc_r;
  logic signed [W-1:0] prevMf_r;
  wire [4:0] accSum = acc_r + bbsd_pkg::OUT_PER_CHIP;
  wire emit = accSum >= osrEff; // RULE3
  wire [4:0] accNxt = emit ? accSum - osrEff : accSum; // RULE4
  wire [2:0] back = 3'(accSum - osrEff);
  wire signed [W:0] dlt = (W+1)'(prevMf_r) - (W+1)'(mfOut);
  wire signed [W+4:0] interp = dlt * $signed({1'b0, back}); // RULE3
  wire signed [W+4:0] ySum = (W+5)'(mfOut) + (interp >>> bbsd_pkg::INTERP_SHIFT);
  wire signed [W-1:0] y = ySum[W-1:0];
  wire srcEmit = fire && emit && !osrChange;

  // Power detectors
  logic [15:0] sigPow_r;
  logic [15:0] noisePow_r;
  logic signed [W-1:0] lastY_r;
  wire signed [W:0] yDiff = (W+1)'(y) - (W+1)'(lastY_r);
  wire signed [W-1:0] yDiffHalf = W'(yDiff >>> 1);
  wire [15:0] sigPowNxt = leak(sigPow_r, sqTop(y)); // RULE5
  wire [15:0] noisePowNxt = leak(noisePow_r, sqTop(yDiffHalf)); // RULE6
  wire [15:0] sigPowScaled = sigPowNxt >> {lowRangeSelect, 1'b0};
  wire [15:0] sigThr = {signalThresholdHighByte, signalThresholdLowByte};
  wire sigHit = sigPowNxt > sigThr; // RULE5
  wire noiseHit = noisePowNxt < noiseThreshold; // RULE7
  wire lowHit = sigPowScaled > 16'(signalLowThreshold); // RULE10
  wire bbsd_pkg::bbsd_mode_type mode = bbsd_pkg::bbsd_mode_type'(recognitionMode);
  logic decision;

  always_comb
  begin
    unique case (mode) // RULE9
      bbsd_pkg::MODE_SIG: decision = sigHit;
      bbsd_pkg::MODE_NOISE: decision = noiseHit;
      bbsd_pkg::MODE_BOTH: decision = sigHit || noiseHit;
      bbsd_pkg::MODE_GATED: decision = sigHit || (noiseHit && lowHit); // RULE10
    endcase
  end

  logic [W-1:0] filtSample_r;
  logic [15:0] signalPowerValue_r;
  logic [15:0] noisePowerValue_r;
  logic signalValid_r;
  logic wakeLevel_r;
  logic recoveredData_r;
  logic recoveredClk_r;
  logic [2:0] chipPhase_r;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sum_r <= '0;
      osrHeld_r <= bbsd_pkg::OSR_MIN;
      acc_r <= bbsd_pkg::ACC_RESET;
      prevMf_r <= '0;
    end
    else if (osrChange)
    begin
      sum_r <= '0;
      osrHeld_r <= osrEff;
      acc_r <= bbsd_pkg::ACC_RESET;
      prevMf_r <= '0;
    end
    else if (fire)
    begin
      sum_r <= sumNxt;
      acc_r <= accNxt;
      prevMf_r <= mfOut;
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      for (int i = 0; i < bbsd_pkg::WIN_LEN; i++)
        win_r[i] <= '0;
    end
    else if (osrChange)
    begin
      for (int i = 0; i < bbsd_pkg::WIN_LEN; i++)
        win_r[i] <= '0;
    end
    else if (fire)
    begin
      win_r[0] <= xIn;
      for (int i = 1; i < bbsd_pkg::WIN_LEN; i++)
        win_r[i] <= win_r[i-1];
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sigPow_r <= bbsd_pkg::POW_RESET;
      noisePow_r <= bbsd_pkg::POW_RESET;
      lastY_r <= '0;
      signalPowerValue_r <= bbsd_pkg::POW_RESET;
      signalValid_r <= 1'b0;
    end
    else if (srcEmit)
    begin
      sigPow_r <= sigPowNxt;
      noisePow_r <= noisePowNxt;
      lastY_r <= y;
      signalPowerValue_r <= lowRangeCalibEnable ? sigPowScaled : sigPowNxt; // RULE5
      signalValid_r <= decision; // RULE19
    end
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      filtValid_r <= 1'b0;
      filtSample_r <= '0;
      chipPhase_r <= bbsd_pkg::CHIP_START;
      recoveredData_r <= 1'b0;
      recoveredClk_r <= 1'b0;
    end
    else if (srcEmit)
    begin
      filtValid_r <= 1'b1;
      filtSample_r <= y;
      chipPhase_r <= chipPhase_r + 3'h1;
      if (chipPhase_r[1:0] == bbsd_pkg::CHIP_HALF_END)
        recoveredClk_r <= !recoveredClk_r; // RULE13
      if (chipPhase_r == bbsd_pkg::CHIP_START)
        recoveredData_r <= !y[W-1]; // RULE13
    end
    else if (filtReady)
      filtValid_r <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      noisePowerValue_r <= bbsd_pkg::POW_RESET;
      wakeLevel_r <= 1'b0;
    end
    else
    begin
      if (serialAccess)
        noisePowerValue_r <= noisePow_r; // RULE8
      wakeLevel_r <= signalValid_r; // RULE12
    end
  end

  assign filtSample = filtSample_r;
  assign filtValid = filtValid_r;
  assign signalPowerValue = signalPowerValue_r;
  assign noisePowerValue = noisePowerValue_r;
  assign signalValid = signalValid_r;
  assign wakeLevel = wakeLevel_r;
  assign recoveredData = recoveredData_r;
  assign recoveredClk = recoveredClk_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstN);

  property p_osr_range;
    fire |-> osrEff >= bbsd_pkg::OSR_MIN && osrEff <= bbsd_pkg::OSR_MAX;
  endproperty
  a_osr_range: assert property (p_osr_range) else $error("oversampling outside 8 to 16"); // RULE1

  property p_out_rate;
    srcEmit && osrEff == bbsd_pkg::OSR_MAX && acc_r == 5'h08 |=> !emit || !fire || osrChange;
  endproperty
  a_out_rate: assert property (p_out_rate) else $error("decimation by two emitted twice in a row"); // RULE3

  property p_emit_valid;
    srcEmit |=> filtValid_r && filtSample_r == $past(y);
  endproperty
  a_emit_valid: assert property (p_emit_valid) else $error("converter sample not presented"); // RULE4

  property p_hold;
    filtValid_r && !filtReady |=> filtValid_r && $stable(filtSample_r);
  endproperty
  a_hold: assert property (p_hold) else $error("output sample dropped under stall"); // RULE4

  property p_sig_mode;
    srcEmit && mode == bbsd_pkg::MODE_SIG |=> signalValid_r == $past(sigHit);
  endproperty
  a_sig_mode: assert property (p_sig_mode) else $error("signal-only decision wrong"); // RULE5

  property p_noise_mode;
    srcEmit && mode == bbsd_pkg::MODE_NOISE |=> signalValid_r == $past(noisePowNxt < noiseThreshold);
  endproperty
  a_noise_mode: assert property (p_noise_mode) else $error("noise-only decision wrong"); // RULE7

  property p_noise_read;
    serialAccess |=> noisePowerValue_r == $past(noisePow_r);
  endproperty
  a_noise_read: assert property (p_noise_read) else $error("noise power not refreshed"); // RULE8

  property p_gated;
    srcEmit && mode == bbsd_pkg::MODE_GATED && !sigHit && !lowHit |=> !signalValid_r;
  endproperty
  a_gated: assert property (p_gated) else $error("noise detect passed without low threshold"); // RULE10

  property p_wake;
    $rose(signalValid_r) |=> wakeLevel_r;
  endproperty
  a_wake: assert property (p_wake) else $error("wake level missed recognition"); // RULE12

  property p_chip_clk;
    srcEmit && chipPhase_r[1:0] == bbsd_pkg::CHIP_HALF_END |=> $changed(recoveredClk_r);
  endproperty
  a_chip_clk: assert property (p_chip_clk) else $error("recovered clock did not toggle"); // RULE13

  property p_stable_flag;
    !srcEmit |=> $stable(signalValid_r);
  endproperty
  a_stable_flag: assert property (p_stable_flag) else $error("flag changed without sample"); // RULE19

  property p_cov_gated;
    srcEmit && mode == bbsd_pkg::MODE_GATED && noiseHit && lowHit;
  endproperty
  c_cov_gated: cover property (p_cov_gated);

  property p_cov_full;
    !sampleReady;
  endproperty
  c_cov_full: cover property (p_cov_full);

  property p_cov_osr16;
    srcEmit && osrEff == bbsd_pkg::OSR_MAX;
  endproperty
  c_cov_osr16: cover property (p_cov_osr16);
endmodule

/* File: testbench/bbsd_demod_model.sv */
// Demodulator sample source and serial access pulses facing the block
`timescale 1ns/1ns
module bbsd_demod_model #(
  parameter int W = 12
) (
  input wire logic ref_clk,
  input wire logic sampleReady,
  output logic [W-1:0] sampleIn,
  output logic sampleValid,
  output logic serialAccess,
  output logic stuck
);
  initial
  begin
    sampleIn = '0;
    sampleValid = 1'b0;
    serialAccess = 1'b0;
    stuck = 1'b0;
  end
  // Offer one sample and hold it until the edge that takes it
  task automatic send(input logic [W-1:0] v, input int gap);
    int k;
    logic r;
    sampleIn = v;
    sampleValid = 1'b1;
    for (k = 0; k < 500; k++)
    begin
      r = sampleReady;
      @(posedge ref_clk);
      #1;
      if (r)
        break;
    end
    if (k == 500)
      stuck = 1'b1;
    if (gap > 0)
    begin
      sampleValid = 1'b0;
      sampleIn = ~v;
      repeat (gap) @(posedge ref_clk);
      #1;
    end
  endtask
  // Released data shows the inverse of the present sampleIn, so the last value again after a gap
  task automatic idle();
    sampleValid = 1'b0;
    sampleIn = ~sampleIn;
  endtask
  // One serial controller access
  task automatic access();
    serialAccess = 1'b1;
    @(posedge ref_clk);
    #1;
    serialAccess = 1'b0;
  endtask
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench of the baseband filter and signal detector
`timescale 1ns/1ns
module testbench;
  localparam int W = 12;
  logic ref_clk, rst_n, sampleReady, sampleValid, serialAccess, stuck;
  logic [W-1:0] sampleIn, filtSample;
  logic [4:0] oversampleRate, row;
  logic [1:0] recognitionMode, lowRangeSelect;
  logic [7:0] sigLo, sigHi, signalLowThreshold;
  logic [15:0] noiseThreshold, signalPowerValue, noisePowerValue, saved;
  logic lowRangeCalibEnable, filtValid, filtReady, signalValid, wakeLevel, recoveredData, recoveredClk;
  logic prevClk, prevValid, stallRandom, stallHold;
  logic [31:0] rndState;
  real mean, dev;
  int bad_count, cmp_count, outCount, clkToggles, taken, o0, i;
  logic [4:0] rows [9] = '{5'h04, 5'h03, 5'h0a, 5'h0d, 5'h12, 5'h11, 5'h1b, 5'h1a, 5'h1c};
  int rates [5] = '{5, 8, 12, 16, 20};

  bbsd_top i_bbsd_top (.ref_clk(ref_clk), .rst_n(rst_n), .sampleIn(sampleIn), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .oversampleRate(oversampleRate), .recognitionMode(recognitionMode),
    .signalThresholdLowByte(sigLo), .signalThresholdHighByte(sigHi), .noiseThreshold(noiseThreshold),
    .signalLowThreshold(signalLowThreshold), .lowRangeCalibEnable(lowRangeCalibEnable),
    .lowRangeSelect(lowRangeSelect), .serialAccess(serialAccess), .signalPowerValue(signalPowerValue),
    .noisePowerValue(noisePowerValue), .filtSample(filtSample), .filtValid(filtValid), .filtReady(filtReady),
    .signalValid(signalValid), .wakeLevel(wakeLevel), .recoveredData(recoveredData),
    .recoveredClk(recoveredClk));
  bbsd_demod_model #(.W(W)) i_bbsd_demod_model (.ref_clk(ref_clk), .sampleReady(sampleReady),
    .sampleIn(sampleIn), .sampleValid(sampleValid), .serialAccess(serialAccess), .stuck(stuck));

  function automatic logic [31:0] xorshift();
    rndState ^= rndState << 13;
    rndState ^= rndState >> 17;
    rndState ^= rndState << 5;
    return rndState;
  endfunction
  // Converter outputs expected for n inputs at a clamped rate
  function automatic int expOuts(input int osr, input int n);
    int r;
    r = osr < 8 ? 8 : (osr > 16 ? 16 : osr);
    return n * 8 / r;
  endfunction
  // Recognition result from mode and the three detector hits
  function automatic logic decide(input logic [4:0] r);
    case (r[4:3])
      2'h0: return r[2];
      2'h1: return r[1];
      2'h2: return r[2] | r[1];
      default: return r[2] | (r[1] & r[0]);
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic feed(input int n, input logic [W-1:0] v, input logic rnd);
    int k;
    for (k = 0; k < n; k++)
      i_bbsd_demod_model.send(rnd ? W'(xorshift()) : v, rnd ? int'(xorshift() % 3) : 0);
    i_bbsd_demod_model.idle();
  endtask
  // Software view: n power readings, one per sample, mean and deviation
  task automatic readings(input int n, input logic [W-1:0] v, input logic rnd, input logic noiseSel,
    output real mn, output real dv);
    int k;
    real p, s, q;
    s = 0.0;
    q = 0.0;
    for (k = 0; k < n; k++)
    begin
      i_bbsd_demod_model.send(rnd ? W'(xorshift()) : v, 1);
      if (noiseSel)
        i_bbsd_demod_model.access();
      p = noiseSel ? real'(noisePowerValue) : real'(signalPowerValue);
      s += p;
      q += p * p;
    end
    mn = s / n;
    p = q / n - mn * mn;
    dv = p > 0.0 ? $sqrt(p) : 0.0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    #1;
    filtReady = stallRandom ? xorshift() % 2 == 0 : stallHold;
  end
  // Output handshakes, clock toggles and wake level follow-up
  always @(negedge ref_clk)
  begin
    if (filtValid === 1'b1 && filtReady === 1'b1)
      outCount++;
    if (rst_n === 1'b1 && recoveredClk !== prevClk)
      clkToggles++;
    prevClk = recoveredClk;
    if (rst_n)
      check(16'(wakeLevel), 16'(prevValid));
    prevValid = signalValid;
  end

  initial
  begin
    rndState = 32'd33;
    rst_n = 1'b0;
    oversampleRate = 5'h08;
    recognitionMode = 2'h0;
    {sigHi, sigLo} = 16'hffff;
    noiseThreshold = 16'h0000;
    signalLowThreshold = 8'h00;
    lowRangeCalibEnable = 1'b0;
    lowRangeSelect = 2'h0;
    stallRandom = 1'b0;
    stallHold = 1'b1;
    prevClk = 1'b0;
    prevValid = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    cyc(3);
    check(16'(sampleReady), 16'h1);
    for (i = 0; i < 5; i++)
    begin
      oversampleRate = 5'(rates[i]);
      cyc(4);
      o0 = outCount;
      stallRandom = 1'b1;
      feed(48, '0, 1'b1);
      stallRandom = 1'b0;
      cyc(40);
      check(16'(outCount - o0), 16'(expOuts(rates[i], 48)));
    end
    $display("Rate conversion test done");
    oversampleRate = 5'h08;
    for (i = 0; i < 9; i++)
    begin
      row = rows[i];
      recognitionMode = row[4:3];
      {sigHi, sigLo} = row[2] ? 16'h0010 : 16'hffff;
      noiseThreshold = row[1] ? 16'hffff : 16'h0000;
      signalLowThreshold = row[0] ? 8'h00 : 8'hff;
      lowRangeSelect = row[0] ? 2'h0 : 2'h3;
      feed(i == 0 ? 160 : 24, 12'h7ff, 1'b0);
      cyc(4);
      check(16'(signalValid), 16'(decide(row)));
    end
    check(16'(filtSample), 16'h07ff);
    check(16'(recoveredData), 16'h1);
    {sigHi, sigLo} = 16'hffff;
    cyc(20);
    check(16'(signalValid), 16'h1);
    feed(8, 12'h7ff, 1'b0);
    cyc(4);
    check(16'(signalValid), 16'h0);
    lowRangeCalibEnable = 1'b1;
    feed(8, 12'h7ff, 1'b0);
    cyc(4);
    check(16'(signalPowerValue <= 16'h00ff), 16'h1);
    lowRangeCalibEnable = 1'b0;
    feed(8, 12'h7ff, 1'b0);
    cyc(4);
    check(16'(signalPowerValue > 16'h00ff), 16'h1);
    feed(16, 12'h801, 1'b0);
    cyc(4);
    check(16'(filtSample), 16'h0801);
    check(16'(recoveredData), 16'h0);
    $display("Detector mode test done");
    check(noisePowerValue, 16'h0000);
    feed(64, '0, 1'b1);
    cyc(4);
    check(noisePowerValue, 16'h0000);
    i_bbsd_demod_model.access();
    check(16'(noisePowerValue != 16'h0000), 16'h1);
    saved = noisePowerValue;
    feed(32, '0, 1'b1);
    check(noisePowerValue, saved);
    $display("Noise refresh test done");
    recognitionMode = 2'h0;
    readings(500, '0, 1'b1, 1'b0, mean, dev);
    {sigHi, sigLo} = 16'($rtoi(mean + 2.0 * dev + 0.5));
    feed(64, 12'h5ff, 1'b0);
    readings(500, 12'h5ff, 1'b0, 1'b0, mean, dev);
    check(16'(mean - 3.0 * dev > real'({sigHi, sigLo})), 16'h1);
    check(16'(signalValid), 16'h1);
    readings(500, '0, 1'b1, 1'b1, mean, dev);
    noiseThreshold = 16'($rtoi(mean - dev + 0.5));
    lowRangeCalibEnable = 1'b1;
    lowRangeSelect = 2'h0;
    feed(64, 12'h5ff, 1'b0);
    readings(50, 12'h5ff, 1'b0, 1'b0, mean, dev);
    for (i = 0; i < 3 && mean >= 200.0; i++)
    begin
      lowRangeSelect = lowRangeSelect + 2'h1;
      readings(50, 12'h5ff, 1'b0, 1'b0, mean, dev);
    end
    signalLowThreshold = 8'($rtoi(0.8 * (mean - 3.0 * dev)));
    lowRangeCalibEnable = 1'b0;
    recognitionMode = 2'h3;
    feed(96, 12'h0ff, 1'b0);
    cyc(4);
    check(16'(signalValid), 16'h0);
    recognitionMode = 2'h1;
    feed(8, 12'h0ff, 1'b0);
    cyc(4);
    check(16'(signalValid), 16'h1);
    $display("Calibration test done");
    stallHold = 1'b0;
    cyc(2);
    o0 = outCount;
    for (taken = 0; taken < 100 && sampleReady; taken++)
      i_bbsd_demod_model.send(W'(xorshift()), 0);
    i_bbsd_demod_model.idle();
    cyc(2);
    check(16'(sampleReady), 16'h0);
    check(16'(taken >= 32), 16'h1);
    stallHold = 1'b1;
    cyc(100);
    check(16'(outCount - o0), 16'(taken));
    check(16'(sampleReady), 16'h1);
    $display("Buffer fill test done");
    check(16'(clkToggles), 16'(outCount / 4));
    check(16'(stuck), 16'h0);
    print_verdict();
  end
endmodule
